// File: pkg/adc_scan_pkg.sv
// constants, timing figures and types for the scan-mode converter sequencer
// assumes one converter state equals one sys_clk cycle at 250 MHz
//
// Overview of operation
// - nonzero mode field selects 4/8/12-channel scan
// - writing start bit to 1 begins scanning
// - channels converted one by one, ascending order
// - start bit stays 1 until software clears
// - pass end sets end flag, next pass follows
// - end interrupt requested while enabled and flag
// - flag cleared by write 0 after read
// - transfer controller service clears end flag
// - writing start bit 0 stops conversions
// - sampling starts after synchronization delay
// - sync delay 10-17 slow, 6-9 fast states
// - sampling lasts 80 slow, 40 fast states
// - first conversion 259-266 slow, 131-134 fast
// - later conversions exactly 256 or 128 states; here longer while the result buffer is full (SEQ_HOLD)
// - trigger falling edge sets start two states later
package adc_scan_pkg;

  // *****************************************************
  // clock and state timing
  // *****************************************************
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned STATE_NS         = 4;
  localparam int unsigned CYC_PER_STATE    = (STATE_NS * CLK_MHZ + 999) / 1000;

  // timing figures in states
  localparam int unsigned SYNC_MIN_SLOW_ST = 10;
  localparam int unsigned SYNC_MAX_SLOW_ST = 17;
  localparam int unsigned SYNC_MIN_FAST_ST = 6;
  localparam int unsigned SYNC_MAX_FAST_ST = 9;
  localparam int unsigned SPL_SLOW_ST      = 80;
  localparam int unsigned SPL_FAST_ST      = 40;
  localparam int unsigned CONV1_MIN_SLOW_ST = 259;
  localparam int unsigned CONV1_MAX_SLOW_ST = 266;
  localparam int unsigned CONV1_MIN_FAST_ST = 131;
  localparam int unsigned CONV1_MAX_FAST_ST = 134;
  localparam int unsigned CONVN_SLOW_ST    = 256;
  localparam int unsigned CONVN_FAST_ST    = 128;

  // *****************************************************
  // counts in clock cycles
  // *****************************************************
  localparam int unsigned CNT_W            = 9;
  localparam logic [CNT_W-1:0] SYNC_MIN_SLOW = CNT_W'(SYNC_MIN_SLOW_ST * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] SYNC_MIN_FAST = CNT_W'(SYNC_MIN_FAST_ST * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] SPL_SLOW      = CNT_W'(SPL_SLOW_ST * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] SPL_FAST      = CNT_W'(SPL_FAST_ST * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] BODY1_SLOW    =
    CNT_W'((CONV1_MIN_SLOW_ST - SYNC_MIN_SLOW_ST) * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] BODY1_FAST    =
    CNT_W'((CONV1_MIN_FAST_ST - SYNC_MIN_FAST_ST) * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] CONVN_SLOW    = CNT_W'(CONVN_SLOW_ST * CYC_PER_STATE);
  localparam logic [CNT_W-1:0] CONVN_FAST    = CNT_W'(CONVN_FAST_ST * CYC_PER_STATE);

  // *****************************************************
  // channels, modes and field layout
  // *****************************************************
  localparam int unsigned NUM_CH           = 12;
  localparam int unsigned CH_W             = 4;
  localparam logic [CH_W-1:0] LAST_CH      = 4'hb;
  localparam logic [1:0] MODE_OFF          = 2'h0;
  localparam logic [1:0] MODE_SCAN4        = 2'h1;
  localparam logic [1:0] MODE_SCAN8        = 2'h2;
  localparam logic [1:0] MODE_SCAN12       = 2'h3;
  localparam int unsigned RESULT_W_DEF     = 10;
  localparam int unsigned FIFO_DEPTH_DEF   = 16;
  localparam logic RESULT_RESET            = 1'b0;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SYNC,
    SEQ_CONVERT,
    SEQ_HOLD
  } seq_state_e;

endpackage

// File: pkg/stream_if.sv
// valid/ready word stream between the sequencer and its result buffer
// assumes both ends run on sys_clk
`timescale 1ns/100ps
interface stream_if #(
  parameter int unsigned W = 14
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: rtl/trigger_edge.sv
// falling-edge detector for the external start trigger
// assumes the pin is already synchronous to sys_clk
`timescale 1ns/100ps
module trigger_edge
  import adc_scan_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // trigger
  input  wire logic ext_trigger_pin_n,
  input  wire logic enable,
  output logic      set_pulse
);

  logic pin_prev_reg;
  logic set_reg;
  wire  logic fall_seen = enable & pin_prev_reg & ~ext_trigger_pin_n;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pin_prev_reg <= 1'b1;
      set_reg      <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= ext_trigger_pin_n;
      set_reg      <= fall_seen;
    end
  end

  assign set_pulse = set_reg;

endmodule

// File: rtl/result_fifo.sv
// result buffer: DEPTH words of storage plus a registered output stage
// assumes one clock; in_s.ready low means the writer must hold its word
`timescale 1ns/100ps
module result_fifo
  import adc_scan_pkg::*;
#(
  parameter int unsigned W     = 14,
  parameter int unsigned DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // streams
  stream_if.snk     in_s,
  stream_if.src     out_s
);

  localparam int unsigned AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
      $error("result_fifo: DEPTH must be a power of two >= 2");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          out_valid_reg;
  logic [W-1:0]  out_data_reg;

  wire logic full     = (count_reg == (AW+1)'(DEPTH));
  wire logic empty    = (count_reg == '0);
  wire logic push     = in_s.valid & ~full;
  wire logic load_out = ~empty & (~out_valid_reg | out_s.ready);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_s.data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (load_out)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load_out);
      if (load_out)
      begin
        out_valid_reg <= 1'b1;
        out_data_reg  <= mem_reg[rd_ptr_reg];
      end
      else if (out_s.ready)
        out_valid_reg <= 1'b0;
    end
  end

  assign in_s.ready = ~full;
  assign out_s.valid = out_valid_reg;
  assign out_s.data  = out_data_reg;

endmodule

// File: rtl/adc_scan_sequencer.sv
// scan-mode sequencer for a twelve-input converter: start bit, channel walk,
// conversion timing, end flag and interrupt, result registers and buffer
// assumes control inputs synchronous to sys_clk; analog_result is valid at
// the last cycle of each conversion
`timescale 1ns/100ps
module adc_scan_sequencer
  import adc_scan_pkg::*;
#(
  parameter int unsigned RESULT_W   = RESULT_W_DEF,
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             srst,
  // configuration bits
  input  wire logic                             scan_mode_sel_hi,
  input  wire logic                             scan_mode_sel_lo,
  input  wire logic [CH_W-1:0]                  channel_select_field,
  input  wire logic                             conv_speed_sel,
  input  wire logic                             end_irq_enable,
  input  wire logic                             ext_trigger_enable,
  // software access to start bit and end flag
  input  wire logic                             start_write,
  input  wire logic                             start_wdata,
  input  wire logic                             flag_read,
  input  wire logic                             flag_clear_write,
  input  wire logic                             transfer_controller_ack,
  // external trigger, active low
  input  wire logic                             ext_trigger_pin_n,
  // analog side
  input  wire logic [RESULT_W-1:0]              analog_result,
  output logic                                  sample_active,
  output logic                                  conv_busy,
  output logic [CH_W-1:0]                       conv_channel,
  // status
  output logic                                  conv_start_bit,
  output logic                                  conv_end_flag,
  output logic                                  conv_end_irq,
  // result registers
  output logic [NUM_CH-1:0][RESULT_W-1:0]       result_regs,
  // result stream
  output logic                                  result_valid,
  output logic [CH_W+RESULT_W-1:0]              result_data,
  input  wire logic                             result_ready
);

  localparam int unsigned FW = CH_W + RESULT_W;

  initial
  begin
    if (RESULT_W < 1 || RESULT_W > 16)
      $error("adc_scan_sequencer: RESULT_W must be 1..16");
    if (FIFO_DEPTH < 2)
      $error("adc_scan_sequencer: FIFO_DEPTH must be at least 2");
  end

  // *****************************************************
  // declarations
  // *****************************************************
  seq_state_e                    state_reg;
  seq_state_e                    state_next;
  logic [CNT_W-1:0]              cnt_reg;
  logic [CNT_W-1:0]              cnt_next;
  logic [CNT_W-1:0]              sync_len_reg;
  logic [CNT_W-1:0]              sync_len_next;
  logic                          first_conv_reg;
  logic                          first_conv_next;
  logic [CH_W-1:0]               ch_reg;
  logic [CH_W-1:0]               ch_next;
  logic                          start_bit_reg;
  logic                          end_flag_reg;
  logic                          flag_armed_reg;
  logic                          irq_reg;
  logic                          sample_reg;
  logic                          busy_reg;
  logic [2:0]                    phase_reg;
  logic [NUM_CH-1:0][RESULT_W-1:0] result_reg;
  logic                          trig_set;

  stream_if #(.W(FW)) push_s ();
  stream_if #(.W(FW)) res_s ();

  // *****************************************************
  // external trigger
  // *****************************************************
  trigger_edge u_trigger_edge (
    .sys_clk           (sys_clk),
    .srst              (srst),
    .ext_trigger_pin_n (ext_trigger_pin_n),
    .enable            (ext_trigger_enable),
    .set_pulse         (trig_set)
  );

  // *****************************************************
  // mode and channel group decode
  // *****************************************************
  wire logic [1:0] mode = {scan_mode_sel_hi, scan_mode_sel_lo};
  wire logic scan_on = (mode != MODE_OFF);

  wire logic [CH_W-1:0] grp_last =
    (channel_select_field > LAST_CH) ? LAST_CH : channel_select_field;

  // group first channel, from the clamped field
  wire logic [CH_W-1:0] grp_first =
    (mode == MODE_SCAN4) ? {grp_last[3:2], 2'h0} :
    (mode == MODE_SCAN8) ? {grp_last[3], 3'h0} :
    '0;

  wire logic pass_end = (ch_reg >= grp_last);
  wire logic [CH_W-1:0] ch_after = pass_end ? grp_first : ch_reg + 1'b1;

  // *****************************************************
  // start bit
  // *****************************************************
  wire logic sw_start_set = start_write & start_wdata;
  wire logic sw_start_clr = start_write & ~start_wdata;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      start_bit_reg <= 1'b0;
    else if (sw_start_set | trig_set)
      start_bit_reg <= 1'b1;
    else if (sw_start_clr)
      start_bit_reg <= 1'b0;
  end

  wire logic run = start_bit_reg & scan_on & ~sw_start_clr;

  // *****************************************************
  // timing selection
  // *****************************************************
  // free-running phase models the unknown clock alignment at start
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      phase_reg <= '0;
    else
      phase_reg <= phase_reg + 1'b1;
  end

  wire logic [CNT_W-1:0] sync_len_sel = conv_speed_sel ?
    SYNC_MIN_FAST + CNT_W'(phase_reg[1:0]) :
    SYNC_MIN_SLOW + CNT_W'(phase_reg);

  // first body keeps total in range
  wire logic [CNT_W-1:0] body_first = conv_speed_sel ? BODY1_FAST : BODY1_SLOW;
  wire logic [CNT_W-1:0] body_later = conv_speed_sel ? CONVN_FAST : CONVN_SLOW;
  wire logic [CNT_W-1:0] body_len   = first_conv_reg ? body_first : body_later;
  wire logic [CNT_W-1:0] spl_len    = conv_speed_sel ? SPL_FAST : SPL_SLOW;

  wire logic sync_done = (cnt_reg == sync_len_reg - 1'b1);
  wire logic body_done = (cnt_reg == body_len - 1'b1);
  wire logic can_push  = push_s.ready;

  // *****************************************************
  // sequencer
  // *****************************************************
  always_comb
  begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    sync_len_next   = sync_len_reg;
    first_conv_next = first_conv_reg;
    ch_next         = ch_reg;
    case (state_reg)
      SEQ_IDLE:
      begin
        if (run)
        begin
          state_next      = SEQ_SYNC;
          cnt_next        = '0;
          sync_len_next   = sync_len_sel;
          first_conv_next = 1'b1;
          ch_next         = grp_first;
        end
      end
      SEQ_SYNC:
      begin
        if (sync_done)
        begin
          state_next = SEQ_CONVERT;
          cnt_next   = '0;
        end
        else
          cnt_next = cnt_reg + 1'b1;
      end
      SEQ_CONVERT:
      begin
        if (body_done)
        begin
          cnt_next        = '0;
          first_conv_next = 1'b0;
          if (can_push)
          begin
            state_next = SEQ_CONVERT;
            ch_next    = ch_after;
          end
          else
            state_next = SEQ_HOLD;
        end
        else
          cnt_next = cnt_reg + 1'b1;
      end
      SEQ_HOLD:
      begin
        // buffer full: the result waits here and timing stretches
        if (can_push)
        begin
          state_next = SEQ_CONVERT;
          cnt_next   = '0;
          ch_next    = ch_after;
        end
      end
      default:
        state_next = SEQ_IDLE;
    endcase
    if (!run)
      state_next = SEQ_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg      <= SEQ_IDLE;
      cnt_reg        <= '0;
      sync_len_reg   <= SYNC_MIN_SLOW;
      first_conv_reg <= 1'b1;
      ch_reg         <= '0;
    end
    else
    begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      sync_len_reg   <= sync_len_next;
      first_conv_reg <= first_conv_next;
      ch_reg         <= ch_next;
    end
  end

  // *****************************************************
  // result capture
  // *****************************************************
  wire logic conv_done_now = (state_reg == SEQ_CONVERT) & body_done & run;
  wire logic hold_push     = (state_reg == SEQ_HOLD) & run;
  wire logic store         = (conv_done_now | hold_push) & can_push;
  wire logic pass_complete = store & pass_end;

  // the held result is kept in the channel register until it can be pushed
  wire logic capture = conv_done_now;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      result_reg <= '0;
    else if (capture)
      result_reg[ch_reg] <= analog_result;
  end

  assign push_s.valid = store;
  assign push_s.data  = {ch_reg, hold_push ? result_reg[ch_reg] : analog_result};

  result_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk (sys_clk),
    .srst    (srst),
    .in_s    (push_s),
    .out_s   (res_s)
  );

  assign res_s.ready = result_ready;

  // *****************************************************
  // end flag and interrupt
  // *****************************************************
  wire logic clear_ok = flag_clear_write & flag_armed_reg;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      end_flag_reg   <= 1'b0;
      flag_armed_reg <= 1'b0;
    end
    else
    begin
      if (pass_complete)
        end_flag_reg <= 1'b1;
      else if (clear_ok)
        end_flag_reg <= 1'b0;
      else if (transfer_controller_ack)
        end_flag_reg <= 1'b0;
      if (flag_read & end_flag_reg)
        flag_armed_reg <= 1'b1;
      else if (flag_clear_write | transfer_controller_ack | ~end_flag_reg)
        flag_armed_reg <= 1'b0;
    end
  end

  wire logic flag_next = pass_complete |
    (end_flag_reg & ~clear_ok & ~transfer_controller_ack);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else
      irq_reg <= flag_next & end_irq_enable;
  end

  // *****************************************************
  // analog side status
  // *****************************************************
  wire logic in_body   = (state_next == SEQ_CONVERT);
  wire logic spl_next  = in_body & (cnt_next < spl_len);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sample_reg <= 1'b0;
      busy_reg   <= 1'b0;
    end
    else
    begin
      sample_reg <= spl_next;
      busy_reg   <= (state_next != SEQ_IDLE);
    end
  end

  // *****************************************************
  // outputs
  // *****************************************************
  assign sample_active  = sample_reg;
  assign conv_busy      = busy_reg;
  assign conv_channel   = ch_reg;
  assign conv_start_bit = start_bit_reg;
  assign conv_end_flag  = end_flag_reg;
  assign conv_end_irq   = irq_reg;
  assign result_regs    = result_reg;
  assign result_valid   = res_s.valid;
  assign result_data    = res_s.data;

endmodule

// File: tb/analog_source_model.sv
// analog source model: a tagged value for the channel being converted
// assumes conv_channel comes from the sequencer in the sys_clk domain
`timescale 1ns/100ps
module analog_source_model
  import adc_scan_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // converter side
  input  wire logic [CH_W-1:0]         conv_channel,
  output logic      [RESULT_W_DEF-1:0] analog_result
);
  logic [5:0] wobble_reg;
  // low bits move every cycle, so a late or early sample shows
  always_ff @(posedge sys_clk)
  begin
    wobble_reg <= srst ? 6'h01 : wobble_reg + 6'h02;
  end
  assign analog_result = {conv_channel, wobble_reg};
endmodule

// File: tb/adc_scan_sequencer_asserts.sv
// concurrent checks on the sequencer's ports
// assumes one sys_clk domain and a synchronous active-high srst
`timescale 1ns/100ps
module adc_scan_sequencer_asserts
  import adc_scan_pkg::*;
(
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            srst,
  // controls
  input wire logic            conv_speed_sel,
  input wire logic            start_write,
  input wire logic            start_wdata,
  input wire logic            flag_read,
  input wire logic            flag_clear_write,
  input wire logic            transfer_controller_ack,
  // observed outputs
  input wire logic            sample_active,
  input wire logic            conv_busy,
  input wire logic [CH_W-1:0] conv_channel,
  input wire logic            conv_start_bit,
  input wire logic            conv_end_flag,
  input wire logic            conv_end_irq
);
  logic             armed_reg;
  logic [CNT_W-1:0] spl_cnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ************
  // helpers
  // ************
  always_ff @(posedge sys_clk)
  begin
    if (srst || flag_clear_write || transfer_controller_ack)
      armed_reg <= 1'b0;
    else if (flag_read && conv_end_flag)
      armed_reg <= 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    spl_cnt_reg <= (srst || !sample_active) ? '0 : spl_cnt_reg + 1'b1;
  end
  // ************
  // properties
  // ************
  a_start_sets: assert property (start_write && start_wdata |=> conv_start_bit)
    else $error("start bit not set");
  a_start_holds: assert property (conv_start_bit && !(start_write && !start_wdata)
    |=> conv_start_bit) else $error("start bit dropped on its own");
  a_stop_idles: assert property ($fell(conv_start_bit) |-> ##[0:2] !conv_busy)
    else $error("busy after stop");
  a_irq_follows: assert property (conv_end_irq |-> conv_end_flag)
    else $error("interrupt without end flag");
  a_clear_needs_read: assert property (conv_end_flag && flag_clear_write && !armed_reg
    && !transfer_controller_ack |=> conv_end_flag) else $error("flag cleared without read");
  a_sample_length: assert property ($fell(sample_active) && conv_start_bit
    |-> spl_cnt_reg == (conv_speed_sel ? SPL_FAST : SPL_SLOW)) else $error("sample length");
  a_sync_delay: assert property ($rose(conv_busy) && !conv_speed_sel
    |-> !sample_active[*5] ##1 !sample_active[*5] ##[1:8] sample_active)
    else $error("sync delay out of range");
  a_channel_ascends: assert property ($changed(conv_channel) && conv_busy && $past(conv_busy)
    |-> conv_channel == $past(conv_channel) + 4'h1
    || (conv_channel[1:0] == 2'h0 && conv_channel < $past(conv_channel)))
    else $error("channel out of order");
  cover property ($rose(conv_end_flag));
  cover property (armed_reg && flag_clear_write);
  cover property ($rose(sample_active) && conv_speed_sel);
endmodule
bind adc_scan_sequencer adc_scan_sequencer_asserts chk (.*);

// File: tb/tb_top.sv
// bench: scan timing, end flag, modes, buffer stall and trigger start
// assumes the analog model beside uut and the checker bound into uut
`timescale 1ns/100ps
module tb_top;
  import adc_scan_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, scan_mode_sel_hi = 1'b0, scan_mode_sel_lo = 1'b0;
  logic conv_speed_sel = 1'b0, end_irq_enable = 1'b1, ext_trigger_enable = 1'b0;
  logic start_write = 1'b0, start_wdata = 1'b0, flag_read = 1'b0, flag_clear_write = 1'b0;
  logic transfer_controller_ack = 1'b0, ext_trigger_pin_n = 1'b1, result_ready = 1'b1;
  logic sample_active, conv_busy, conv_start_bit, conv_end_flag, conv_end_irq, result_valid;
  logic [CH_W-1:0]                     channel_select_field = 4'h0;
  logic [CH_W-1:0]                     conv_channel;
  logic [RESULT_W_DEF-1:0]             analog_result;
  logic [NUM_CH-1:0][RESULT_W_DEF-1:0] result_regs;
  logic [CH_W+RESULT_W_DEF-1:0]        result_data;
  logic [CH_W+RESULT_W_DEF-1:0]        words[$];
  int                                  times[$];
  int                                  fail_count = 0, checks_done = 0, cyc = 0;
  adc_scan_sequencer uut (.*);
  analog_source_model src (.*);
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ************
  // collector and timeout
  // ************
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (result_valid === 1'b1 && result_ready === 1'b1)
    begin
      words.push_back(result_data);
      times.push_back(cyc);
    end
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, want, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic write_start(logic value);
    @(posedge sys_clk);
    start_write <= 1'b1;
    start_wdata <= value;
    @(posedge sys_clk);
    start_write <= 1'b0;
    #1;
  endtask
  task automatic strobe(logic rd, logic clr, logic ack);
    @(posedge sys_clk);
    flag_read <= rd;
    flag_clear_write <= clr;
    transfer_controller_ack <= ack;
    @(posedge sys_clk);
    {flag_read, flag_clear_write, transfer_controller_ack} <= 3'h0;
    #1;
  endtask
  // settings change only while the start bit is 0
  task automatic configure(logic [1:0] mode, logic [3:0] field, logic fast, logic rdy);
    @(posedge sys_clk);
    {scan_mode_sel_hi, scan_mode_sel_lo} <= mode;
    channel_select_field <= field;
    conv_speed_sel <= fast;
    result_ready <= rdy;
    words.delete();
    times.delete();
    #1;
  endtask
  task automatic stop_scan;
    int n;
    write_start(1'b0);
    tick(10);
    check("stopped", {conv_start_bit, conv_busy}, 0);
    n = words.size();
    tick(300);
    check("words after stop", words.size() - n, 0);
  endtask
  // ************
  // scenarios
  // ************
  task automatic scan_four;
    int t_busy;
    configure(MODE_SCAN4, 4'h1, 1'b0, 1'b1);
    write_start(1'b1);
    check("start bit", conv_start_bit, 1);
    while (conv_busy !== 1'b1) tick(1);
    t_busy = cyc;
    check("first channel", conv_channel, 0);
    while (result_regs[0] === '0) tick(1);
    check("first conversion", (cyc - t_busy) inside {[259:266]}, 1);
    while (conv_end_flag !== 1'b1) tick(1);
    check("end irq", conv_end_irq, 1);
    strobe(1'b0, 1'b1, 1'b0);
    check("flag without read", conv_end_flag, 1);
    strobe(1'b1, 1'b0, 1'b0);
    strobe(1'b0, 1'b1, 1'b0);
    check("flag after read", {conv_end_flag, conv_end_irq}, 0);
    @(posedge sys_clk);
    end_irq_enable <= 1'b0;
    while (conv_end_flag !== 1'b1) tick(1);
    check("irq masked", conv_end_irq, 0);
    strobe(1'b0, 1'b0, 1'b1);
    check("flag after service", conv_end_flag, 0);
    check("start bit kept", conv_start_bit, 1);
    @(posedge sys_clk);
    end_irq_enable <= 1'b1;
    stop_scan();
    check("order", {words[0][13:10], words[1][13:10], words[2][13:10], words[3][13:10]},
          16'h0101);
    check("later conversion", times[2] - times[1], 256);
    check("stored", {result_regs[1][9:6], result_regs[2]}, 14'h0400);
  endtask
  task automatic scan_modes;
    logic [1:0] mode[3] = '{MODE_SCAN8, MODE_SCAN12, MODE_OFF};
    logic [3:0] field[3] = '{4'h9, 4'h2, 4'h5};
    int base[3] = '{8, 0, 0};
    int count[3] = '{2, 3, 0};
    for (int m = 0; m < 3; m++)
    begin
      configure(mode[m], field[m], 1'b1, 1'b1);
      write_start(1'b1);
      tick(count[m] * 128 + 200);
      check("busy", conv_busy, count[m] > 0);
      for (int k = 0; k <= count[m] && count[m] > 0; k++)
        check("walk", words[k][13:10], (k == count[m]) ? base[m] : base[m] + k);
      if (count[m] > 0)
        check("fast conversion", times[2] - times[1], 128);
      stop_scan();
    end
  endtask
  task automatic fill_buffer;
    int high = 0;
    configure(MODE_SCAN12, 4'hb, 1'b1, 1'b0);
    write_start(1'b1);
    tick(20 * 128 + 200);
    repeat (200)
    begin
      tick(1);
      high += sample_active;
    end
    check("stall while full", {high[7:0], conv_busy, result_valid}, 10'h003);
    write_start(1'b0);
    configure(MODE_SCAN12, 4'hb, 1'b1, 1'b1);
    tick(40);
    check("drained", words.size() inside {[FIFO_DEPTH_DEF + 1:FIFO_DEPTH_DEF + 2]}, 1);
    check("word order", words[FIFO_DEPTH_DEF][13:10], 4);
  endtask
  task automatic trigger_start;
    configure(MODE_SCAN4, 4'h0, 1'b0, 1'b1);
    @(posedge sys_clk);
    ext_trigger_enable <= 1'b1;
    ext_trigger_pin_n <= 1'b0;
    tick(1);
    check("start too early", conv_start_bit, 0);
    tick(1);
    check("start by trigger", conv_start_bit, 1);
    @(posedge sys_clk);
    ext_trigger_enable <= 1'b0;
    ext_trigger_pin_n <= 1'b1;
    tick(60);
    stop_scan();
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    tick(1);
    check("reset", {conv_start_bit, conv_busy, conv_end_flag, result_valid}, 0);
    check("reset results", 32'(|result_regs), 0);
    scan_four();
    scan_modes();
    fill_buffer();
    trigger_start();
    close_out();
  end
endmodule
